/* rtl/acs_clock_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"

module acs_clock_test (
   // System clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // Oscillator and select pins (asynchronous)
   input wire logic osc_i,
   input wire logic osc_sel_i,
   // Test pin level code: 00 ground, 01 mid, 1x high
   input wire logic [1:0] test_lvl_i,
   // Integrator comparator crossing (asynchronous)
   input wire logic comp_i,
   // Clock outputs
   output logic int_clk_o,
   output logic clk_fast_o,
   // Conversion outputs
   output acs_pkg::acs_phase_t phase_o,
   output acs_pkg::acs_result_t result_o
);

   // ***************************************************************
   // Input synchronisers
   // ***************************************************************

   // Two-stage chains; stage one only feeds stage two
   logic [4:0] sync1_q, sync1_d;
   logic [4:0] sync2_q, sync2_d;
   // Extra stage of the oscillator for edge detection
   logic osc_q3, osc_d3;

   // Raw pins gathered into one vector
   always_comb begin
      sync1_d = {comp_i, test_lvl_i, osc_sel_i, osc_i};
      sync2_d = sync1_q;
      osc_d3 = sync2_q[0];
   end

   // Register the chains
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         sync1_q <= 5'h02;
         sync2_q <= 5'h02;
         osc_q3 <= 1'b0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         osc_q3 <= osc_d3;
      end
   end

   // Synchronised views
   logic osc_s;
   logic sel_s;
   logic comp_s;
   logic osc_rise;
   acs_pkg::acs_lvl_t lvl;

   // R10 three-level decode
   always_comb begin
      osc_s = sync2_q[0];
      sel_s = sync2_q[1];
      comp_s = sync2_q[4];
      osc_rise = osc_s & ~osc_q3;
      if (sync2_q[3:2] == `ACS_TST_GND) begin
         lvl = acs_pkg::ACS_LVL_GND;
      end else if (sync2_q[3:2] == `ACS_TST_MID) begin
         lvl = acs_pkg::ACS_LVL_MID;
      end else begin
         lvl = acs_pkg::ACS_LVL_HIGH;
      end
   end

   // ***************************************************************
   // Internal clock generation
   // ***************************************************************

   // Prescaler edge count and divided clock
   logic [`ACS_DIV_W-1:0] div_q, div_d;
   logic div_clk_q, div_clk_d;
   logic int_clk_q, int_clk_d;
   logic tick;

   // Select source, divide, or stop
   always_comb begin
      div_d = div_q;
      div_clk_d = div_clk_q;
      int_clk_d = int_clk_q;
      if (lvl == acs_pkg::ACS_LVL_GND) begin
         // R5 clock stopped
         div_d = '0;
         div_clk_d = 1'b0;
         int_clk_d = 1'b0;
      end else if (sel_s) begin
         // R1 direct pass, no division
         // R4 duty and phase kept
         int_clk_d = osc_s;
         div_d = '0;
         div_clk_d = 1'b0;
      end else begin
         // R2 divide by 58
         if (osc_rise) begin
            if (div_q == `ACS_DIV_W'(`ACS_DIV_HALF - 1)) begin
               div_d = '0;
               div_clk_d = ~div_clk_q;
            end else begin
               div_d = div_q + `ACS_DIV_W'(1);
            end
         end
         int_clk_d = div_clk_d;
      end
   end

   // One tick per internal clock rising edge
   assign tick = int_clk_d & ~int_clk_q;

   // Register the clock state
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         div_q <= '0;
         div_clk_q <= 1'b0;
         int_clk_q <= 1'b0;
      end else begin
         div_q <= div_d;
         div_clk_q <= div_clk_d;
         int_clk_q <= int_clk_d;
      end
   end

   // ***************************************************************
   // Internal clock rate watch
   // ***************************************************************

   // Cycles since last tick; saturates, so slow clocks never wrap
   logic [`ACS_PER_W-1:0] per_q, per_d;
   logic fast_q, fast_d;

   // R9 flag periods shorter than the fastest rated clock
   always_comb begin
      per_d = per_q;
      fast_d = fast_q;
      if (tick) begin
         fast_d = (per_q < `ACS_PER_W'(`ACS_MIN_PER_CYC)) && (per_q != '0);
         per_d = `ACS_PER_W'(1);
      end else if (per_q != '1) begin
         per_d = per_q + `ACS_PER_W'(1);
      end
   end

   // Register the watch
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         per_q <= '0;
         fast_q <= 1'b0;
      end else begin
         per_q <= per_d;
         fast_q <= fast_d;
      end
   end

   // ***************************************************************
   // Conversion counter and output latches
   // ***************************************************************

   acs_pkg::acs_phase_t phase_q, phase_d;
   logic [`ACS_CNT_W-1:0] cnt_q, cnt_d;
   logic over_q, over_d;
   logic preset_q, preset_d;
   acs_pkg::acs_result_t latch_q, latch_d;

   // Phase sequencing, counting, test forcing and latch control
   always_comb begin
      phase_d = phase_q;
      cnt_d = cnt_q;
      over_d = over_q;
      preset_d = preset_q;
      latch_d = latch_q;
      if (lvl == acs_pkg::ACS_LVL_GND) begin
         // R5 counter forced high
         cnt_d = '1;
         over_d = 1'b1;
         preset_d = 1'b1;
         latch_d = '1;
         phase_d = acs_pkg::ACS_INTEG;
      end else if (preset_q) begin
         // R6 first clock clears counter
         if (tick) begin
            cnt_d = '0;
            over_d = 1'b0;
            preset_d = 1'b0;
            // Outputs drop with the counter whichever level the pin left for
            latch_d = '0;
         end
      end else if (tick) begin
         unique case (phase_q)
            acs_pkg::ACS_INTEG: begin
               // R3 exactly 2048 clocks
               if (cnt_q == `ACS_CNT_W'(`ACS_INT_CLKS - 1)) begin
                  cnt_d = '0;
                  over_d = 1'b0;
                  phase_d = acs_pkg::ACS_DEINT;
               end else begin
                  cnt_d = cnt_q + `ACS_CNT_W'(1);
               end
            end
            acs_pkg::ACS_DEINT: begin
               // R8 full scale 4096 counts
               if (comp_s) begin
                  phase_d = acs_pkg::ACS_LOAD;
               end else if (cnt_q == `ACS_CNT_W'(`ACS_FULL_SCALE - 1)) begin
                  over_d = 1'b1;
                  phase_d = acs_pkg::ACS_LOAD;
               end else begin
                  cnt_d = cnt_q + `ACS_CNT_W'(1);
               end
            end
            acs_pkg::ACS_LOAD: begin
               // Result captured at high level, start next integration
               if (lvl == acs_pkg::ACS_LVL_HIGH) begin
                  latch_d = '{over: over_q, data: cnt_q};
               end
               cnt_d = '0;
               over_d = 1'b0;
               phase_d = acs_pkg::ACS_INTEG;
            end
            default: begin
               phase_d = acs_pkg::ACS_INTEG;
            end
         endcase
      end
      // R7 mid level: latches transparent
      if (lvl == acs_pkg::ACS_LVL_MID) begin
         latch_d = '{over: over_d, data: cnt_d};
      end
   end

   // Register the converter state
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         phase_q <= acs_pkg::ACS_INTEG;
         cnt_q <= '0;
         over_q <= 1'b0;
         preset_q <= 1'b0;
         latch_q <= '0;
      end else begin
         phase_q <= phase_d;
         cnt_q <= cnt_d;
         over_q <= over_d;
         preset_q <= preset_d;
         latch_q <= latch_d;
      end
   end

   // ***************************************************************
   // Outputs, all straight from flip-flops
   // ***************************************************************

   assign int_clk_o = int_clk_q;
   assign clk_fast_o = fast_q;
   assign phase_o = phase_q;
   assign result_o = latch_q;

endmodule

`default_nettype wire

/* include/acs_map.svh */
// Notes on behaviour
// R1 - Select high or open: clock follows oscillator
// R2 - Select low: internal clock is input over 58
// R3 - Integration lasts exactly 2048 internal clocks
// R4 - Overdriven input copied in duty, phase, frequency
// R5 - Test at ground: clock stops, counter high
// R6 - First clock after ground clears counter
// R7 - Test mid level: output latches transparent
// R8 - Full scale reading is 4096 counts
// R9 - Internal clock up to 245.8 kHz supported
// R10 - Test pin decoded into three levels
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// ***************************************************************
// Clock source and prescaler
// ***************************************************************
`define ACS_DIV_RATIO 58
`define ACS_DIV_HALF 29
`define ACS_DIV_W 5

// ***************************************************************
// Conversion lengths
// ***************************************************************
`define ACS_INT_CLKS 2048
`define ACS_FULL_SCALE 4096
`define ACS_CNT_W 12

// ***************************************************************
// Timing: system clock and fastest internal clock
// ***************************************************************
`define ACS_SYS_HZ 50000000
`define ACS_FMAX_HZ 245800
`define ACS_MIN_PER_CYC ((`ACS_SYS_HZ + `ACS_FMAX_HZ - 1) / `ACS_FMAX_HZ)
`define ACS_PER_W 9

// ***************************************************************
// Test pin level codes from the external level detector
// ***************************************************************
`define ACS_TST_GND 2'h0
`define ACS_TST_MID 2'h1

`endif

/* include/acs_pkg.sv */
package acs_pkg;

   // Conversion phase
   typedef enum logic [1:0] {
      ACS_INTEG = 2'b00,
      ACS_DEINT = 2'b01,
      ACS_LOAD = 2'b10
   } acs_phase_t;

   // Decoded test pin level
   typedef enum logic [1:0] {
      ACS_LVL_GND = 2'b00,
      ACS_LVL_MID = 2'b01,
      ACS_LVL_HIGH = 2'b10
   } acs_lvl_t;

   // Result word as seen at the counter outputs
   typedef struct packed {
      logic over;
      logic [11:0] data;
   } acs_result_t;

endpackage

/* tb/acs_clock_test_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_clock_test_chk (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // Pins
   input wire logic osc_i,
   input wire logic osc_sel_i,
   input wire logic [1:0] test_lvl_i,
   input wire logic comp_i,
   // Outputs
   input wire logic int_clk_o,
   input wire logic clk_fast_o,
   input wire acs_pkg::acs_phase_t phase_o,
   input wire acs_pkg::acs_result_t result_o
);
   // Cycles since reset; past values are stale below seven
   logic [2:0] run_q;
   logic [2:0] run_d;
   always_comb run_d = (run_q == 3'h7) ? run_q : run_q + 3'h1;
   always_ff @(posedge clk_sys_i) run_q <= srst_i ? 3'h0 : run_d;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   direct_follow_a: assert property (
      run_q == 3'h7 && osc_sel_i && $past(osc_sel_i, 4) && test_lvl_i != 2'h0
      && $past(test_lvl_i, 4) != 2'h0 |-> int_clk_o == $past(osc_i, 3))
      else $error("clock not following pin");
   gnd_preset_a: assert property (
      (test_lvl_i == 2'h0) [*4] |-> result_o == 13'h1fff && phase_o == acs_pkg::ACS_INTEG)
      else $error("no preset at ground");
   gnd_clk_stop_a: assert property ((test_lvl_i == 2'h0) [*4] |-> !int_clk_o)
      else $error("clock runs at ground");
   preset_clear_a: assert property (
      test_lvl_i == 2'h1 && $past(result_o) == 13'h1fff && result_o != 13'h1fff
      |-> result_o == 13'h0)
      else $error("preset not cleared");
   mid_count_a: assert property (
      test_lvl_i == 2'h1 && $past(test_lvl_i, 4) == 2'h1 && $changed(result_o)
      && phase_o == acs_pkg::ACS_INTEG && $past(phase_o) == acs_pkg::ACS_INTEG
      && result_o.data != 12'h0 && $past(result_o) != 13'h1fff
      |-> result_o.data == $past(result_o.data) + 12'h1)
      else $error("live count skipped");
   latch_hold_a: assert property (
      run_q == 3'h7 && test_lvl_i[1] && $past(test_lvl_i[1], 4)
      && $past(phase_o) != acs_pkg::ACS_LOAD && $past(phase_o, 2) != acs_pkg::ACS_LOAD
      |-> $stable(result_o) || ($past(result_o) == 13'h1fff && result_o == 13'h0))
      else $error("latch changed outside load");
   phase_order_a: assert property ($changed(phase_o) |-> phase_o == acs_pkg::ACS_INTEG
      || 2'(phase_o) == 2'($past(phase_o)) + 2'h1)
      else $error("bad phase order");
   over_full_a: assert property (result_o.over |-> result_o.data == 12'hfff)
      else $error("over without full scale");
endmodule
bind acs_clock_test acs_clock_test_chk u_chk (.clk_sys_i, .srst_i, .osc_i, .osc_sel_i,
   .test_lvl_i, .comp_i, .int_clk_o, .clk_fast_o, .phase_o, .result_o);
`default_nettype wire

/* tb/acs_osc_src.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_osc_src #(
   // Half period of the overdrive signal
   parameter int HALF_NS = 40
) (
   // Oscillator input pin
   output logic osc_o
);
   // overdrive drives the input pin only
   initial begin
      osc_o = 1'b0;
      forever #(HALF_NS) osc_o = ~osc_o;
   end
endmodule
`default_nettype wire

/* tb/adc_clock_select_and_counter_test_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_clock_select_and_counter_test_tb;
   logic clk_sys_i = 1'b0;
   logic srst_i = 1'b1;
   logic osc_sel_i = 1'b1;
   logic [1:0] test_lvl_i = 2'h0;
   logic comp_i = 1'b0;
   logic osc_i, int_clk_o, clk_fast_o;
   acs_pkg::acs_phase_t phase_o;
   acs_pkg::acs_result_t result_o;
   int bad_count = 0;
   int checks = 0;
   int n;
   always #10 clk_sys_i = ~clk_sys_i;
   acs_osc_src OSC (.osc_o(osc_i));
   acs_clock_test DUT (.clk_sys_i, .srst_i, .osc_i, .osc_sel_i, .test_lvl_i, .comp_i,
      .int_clk_o, .clk_fast_o, .phase_o, .result_o);
   // Inputs move one ns after the edge, outputs are read then too
   task step(input int k);
      repeat (k) @(posedge clk_sys_i);
      #1;
   endtask
   task chk(input string what, input logic [12:0] exp, input logic [12:0] got);
      checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask
   task wait_ph(input acs_pkg::acs_phase_t p);
      for (int i = 0; i < 30000 && phase_o !== p; i++) step(1);
      if (phase_o !== p) begin
         $display("BAD wait_phase expected %h seen %h", p, phase_o);
         bad_count++;
      end
   endtask
   task wait_clk(input logic v);
      for (int i = 0; i < 2000 && int_clk_o !== v; i++) step(1);
      if (int_clk_o !== v) begin
         $display("BAD wait_clock expected %h seen %h", v, int_clk_o);
         bad_count++;
      end
   endtask
   task t_ground;
      step(10);
      chk("preset", 13'h1fff, result_o);
      chk("clk_stop", 13'h0, {12'h0, int_clk_o});
   endtask
   task t_mid;
      test_lvl_i = 2'h1;
      for (n = 0; n < 100 && result_o !== 13'h0; n++) step(1);
      chk("clear", 13'h0, result_o);
      step(200);
      chk("live", 13'h1, {12'h0, result_o !== 13'h0});
      chk("fast", 13'h1, {12'h0, clk_fast_o});
   endtask
   // Overdrive period is 4 cycles, so integration spans 8192 cycles
   task t_conv;
      test_lvl_i = 2'h2;
      wait_ph(acs_pkg::ACS_LOAD);
      wait_ph(acs_pkg::ACS_INTEG);
      for (n = 0; n < 9000 && phase_o !== acs_pkg::ACS_DEINT; n++) step(1);
      chk("integ_len", 13'h1, {12'h0, n >= 8191 && n <= 8193});
      wait_ph(acs_pkg::ACS_LOAD);
      step(8);
      chk("full_scale", 13'h1fff, result_o);
   endtask
   task t_comp;
      wait_ph(acs_pkg::ACS_DEINT);
      step(400);
      comp_i = 1'b1;
      wait_ph(acs_pkg::ACS_LOAD);
      step(8);
      comp_i = 1'b0;
      chk("over", 13'h0, {12'h0, result_o.over});
      chk("ramp", 13'h1, {12'h0, result_o.data > 12'd95 && result_o.data < 12'd105});
   endtask
   // Divided clock stays high for 29 overdrive periods of 4 cycles
   task t_div;
      osc_sel_i = 1'b0;
      // Code 11 must decode as high as well
      test_lvl_i = 2'h3;
      step(1000);
      wait_clk(1'b0);
      wait_clk(1'b1);
      for (n = 0; n < 300 && int_clk_o === 1'b1; n++) step(1);
      chk("div_high", 13'd116, 13'(n));
      chk("slow", 13'h0, {12'h0, clk_fast_o});
   endtask
   // Ground again, then straight to high: first divided tick clears outputs
   task t_regnd;
      test_lvl_i = 2'h0;
      step(6);
      chk("preset_again", 13'h1fff, result_o);
      test_lvl_i = 2'h2;
      for (n = 0; n < 300 && result_o !== 13'h0; n++) step(1);
      chk("clear_high", 13'h0, result_o);
      chk("clear_wait", 13'h1, {12'h0, n >= 100 && n <= 130});
   endtask
   task print_verdict;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #2000000;
      bad_count++;
      print_verdict;
   end
   initial begin
      step(6);
      srst_i = 1'b0;
      t_ground;
      t_mid;
      t_conv;
      t_comp;
      t_div;
      t_regnd;
      print_verdict;
   end
endmodule
`default_nettype wire
